// *** pkg/local_mem_defines.vh ***
`ifndef LOCAL_MEM_DEFINES_VH
`define LOCAL_MEM_DEFINES_VH

// Power-up strap layout on the multiplexed bus
`define STRAP_SLOW_BIT      0
`define STRAP_SIZE_LSB      1
`define STRAP_SIZE_MSB      3
`define SIZE_CODE_NONE      3'h7
// Size codes above this one need more than 16 address bits
`define SIZE_CODE_16BIT_MAX 3'h2
// Interrupt drive select bit position in the DMA control register
`define DMA_CTRL_IRQ_TOTEM_BIT 3
// Extra data cycles for slow memory
`define SLOW_EXTRA_CYCLES   4'h2
// Base data-phase length in cycles
`define DATA_BASE_CYCLES    4'h2
// Strobe pulse width in cycles
`define STROBE_CYCLES       4'h1
// First and last lane numbers
`define LANE_LAST           2'h3
`define LANE_FIRST          2'h0

`endif

// *** core/byte_fifo.v ***
`timescale 1ns/100ps
module byte_fifo #(
  parameter WIDTH = 8,
  parameter DEPTH = 8,
  parameter AW    = 3
) (
  input  wire             clk_i,
  input  wire             nrst_i,
  input  wire [WIDTH-1:0] in_data_i,
  input  wire             in_valid_i,
  output wire             in_ready_o,
  output wire [WIDTH-1:0] out_data_o,
  output wire             out_valid_o,
  input  wire             out_ready_i
);
  reg [WIDTH-1:0] mem [0:DEPTH-1];
  reg [AW-1:0]    wr_ptr_reg;
  reg [AW-1:0]    rd_ptr_reg;
  reg [AW:0]      count_reg;
  wire            push;
  wire            pop;

  // Honest full and empty from a shared count
  assign in_ready_o  = (count_reg != DEPTH[AW:0]);
  assign out_valid_o = (count_reg != {(AW+1){1'b0}});
  assign out_data_o  = mem[rd_ptr_reg];
  assign push        = in_valid_i & in_ready_o;
  assign pop         = out_valid_o & out_ready_i;

  // Storage has no reset; only pointers matter
  always @(posedge clk_i) begin
    if (push) begin
      mem[wr_ptr_reg] <= in_data_i;
    end
  end

  // Pointer and count update
  always @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      wr_ptr_reg <= {AW{1'b0}};
      rd_ptr_reg <= {AW{1'b0}};
      count_reg  <= {(AW+1){1'b0}};
    end else begin
      if (push) begin
        wr_ptr_reg <= (wr_ptr_reg == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}}
                      : wr_ptr_reg + 1'b1;
      end
      if (pop) begin
        rd_ptr_reg <= (rd_ptr_reg == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}}
                      : rd_ptr_reg + 1'b1;
      end
      if (push & ~pop) begin
        count_reg <= count_reg + 1'b1;
      end else if (pop & ~push) begin
        count_reg <= count_reg - 1'b1;
      end
    end
  end
endmodule

// *** core/local_mem_port.v ***
// What this block does
// (R1) Interrupt pin goes low while an interrupt condition is pending.
// (R2) Drive-select bit picks open drain with pull-up or totem pole drive.
// (R3) Byte order low: first storage byte lands on host lane zero, ascending.
// (R4) Byte order low: host lane zero goes out first, then ascending lanes.
// (R5) Byte order high: lane three first, descending, both directions.
// (R6) Little endian: location 0 on lane zero, location 3 on lane three.
// (R7) Big endian: location 0 on lane three, location 3 on lane zero.
// (R8) Address up to 20 bits sent a byte at a time, high byte first.
// (R9) Low strobe pulses to latch the least significant address byte.
// (R10) Middle strobe pulses to latch address bits 15 to 8.
// (R11) Shared pin is high strobe only if size over 16 bits and ROM enabled.
// (R12) Write strobe asserted low while writing data to flash.
// (R13) Read enable asserted low only during reads.
// (R14) Chip select asserted low to select the memory for accesses.
// (R15) After addressing, the bus carries write data out or read data in.
// (R16) Slow-memory strap low adds two cycles to each data access.
// (R17) Three-bit size strap: 16 KB doubling to 1024 KB, 111 means none.
// (R18) All address bytes strobed before chip select and data strobes.
`timescale 1ns/100ps
`include "local_mem_defines.vh"
module local_mem_port #(
  parameter FIFO_DEPTH = 8,
  parameter FIFO_AW    = 3
) (
  input  wire        clk_i,
  input  wire        nrst_i,
  // Host side request
  input  wire        req_valid_i,
  input  wire        req_write_i,
  input  wire [19:0] req_addr_i,
  input  wire [31:0] req_wdata_i,
  output reg         req_ready_o,
  output reg  [31:0] rsp_rdata_o,
  output reg         rsp_valid_o,
  // Configuration and status
  input  wire        byte_order_select_i,
  input  wire        rom_base_enable_i,
  input  wire [7:0]  dma_control_reg_i,
  input  wire        irq_pending_i,
  input  wire        gpio_out_i,
  input  wire        gpio_oe_n_i,
  output reg         gpio_in_o,
  output reg  [2:0]  mem_size_code_o,
  output reg         slow_mem_o,
  output reg         no_ext_mem_o,
  // Interrupt pin, three signals
  output reg         irq_n_o,
  output reg         irq_oe_n_o,
  output reg         irq_pullup_o,
  // Local memory pins
  input  wire [7:0]  local_addr_data_bus_i,
  output reg  [7:0]  local_addr_data_bus_o,
  output reg         local_addr_data_bus_oe_n_o,
  output reg         addr_strobe_low_n_o,
  output reg         addr_strobe_mid_n_o,
  input  wire        gp_pin_or_addr_strobe_high_i,
  output reg         gp_pin_or_addr_strobe_high_o,
  output reg         gp_pin_or_addr_strobe_high_oe_n_o,
  output reg         local_write_strobe_n_o,
  output reg         local_read_enable_n_o,
  output reg         local_chip_select_n_o
);
  localparam [6:0] ST_STRAP = 7'h01;
  localparam [6:0] ST_IDLE  = 7'h02;
  localparam [6:0] ST_ADDR  = 7'h04;
  localparam [6:0] ST_STRB  = 7'h08;
  localparam [6:0] ST_DATA  = 7'h10;
  localparam [6:0] ST_NEXT  = 7'h20;
  localparam [6:0] ST_DONE  = 7'h40;

  reg [6:0]  state_reg;
  reg [1:0]  abyte_reg;
  reg [1:0]  beat_reg;
  reg [3:0]  cnt_reg;
  reg        write_reg;
  reg [19:0] addr_reg;
  reg [31:0] rdata_reg;
  reg        high_strobe_en_reg;
  wire       fifo_in_ready;
  wire [7:0] fifo_out_data;
  wire       fifo_out_valid;
  wire       fifo_in_valid;
  wire       fifo_out_ready;
  wire [3:0] data_cycles;
  wire [1:0] first_abyte;
  wire [1:0] lane;

  // Host lane for a given memory beat
  function [1:0] lane_of;
    input [1:0] beat;
    input       big;
    begin
      lane_of = big ? (`LANE_LAST - beat) : beat; // [R5] [R6] [R7]
    end
  endfunction

  // Pick a byte lane out of a word
  function [7:0] lane_byte;
    input [31:0] word;
    input [1:0]  ln;
    begin
      lane_byte = word[ln*8 +: 8];
    end
  endfunction

  assign data_cycles = slow_mem_o ? (`DATA_BASE_CYCLES + `SLOW_EXTRA_CYCLES)
                       : `DATA_BASE_CYCLES; // [R16]
  // Skip the top byte when only 16 address bits are strobed
  assign first_abyte = high_strobe_en_reg ? 2'h2 : 2'h1; // [R8]
  assign lane        = lane_of(beat_reg, byte_order_select_i);
  // Write bytes go straight out by lane; only reads queue bytes from the bus
  // A full queue would lose the byte; one pop per push keeps it shallow
  assign fifo_in_valid  = (state_reg == ST_DATA) & ~write_reg
                          & (cnt_reg == 4'h1) & fifo_in_ready;
  assign fifo_out_ready = (state_reg == ST_NEXT);

  byte_fifo #(
    .WIDTH (8),
    .DEPTH (FIFO_DEPTH),
    .AW    (FIFO_AW)
  ) u_fifo (
    .clk_i       (clk_i),
    .nrst_i      (nrst_i),
    .in_data_i   (local_addr_data_bus_i),
    .in_valid_i  (fifo_in_valid),
    .in_ready_o  (fifo_in_ready),
    .out_data_o  (fifo_out_data),
    .out_valid_o (fifo_out_valid),
    .out_ready_i (fifo_out_ready)
  );

  // Interrupt pin drive
  always @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      irq_n_o      <= 1'b1;
      irq_oe_n_o   <= 1'b1;
      irq_pullup_o <= 1'b1;
    end else begin
      irq_n_o <= ~irq_pending_i; // [R1]
      // Open drain only drives while low; totem pole always drives
      if (dma_control_reg_i[`DMA_CTRL_IRQ_TOTEM_BIT]) begin // [R2]
        irq_oe_n_o   <= 1'b0;
        irq_pullup_o <= 1'b0;
      end else begin
        irq_oe_n_o   <= ~irq_pending_i;
        irq_pullup_o <= 1'b1;
      end
    end
  end

  // Shared pin: high strobe or plain general-purpose I/O
  always @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      gpio_in_o <= 1'b0;
      high_strobe_en_reg <= 1'b0;
      gp_pin_or_addr_strobe_high_o      <= 1'b1;
      gp_pin_or_addr_strobe_high_oe_n_o <= 1'b1;
    end else begin
      gpio_in_o <= gp_pin_or_addr_strobe_high_i;
      high_strobe_en_reg <= rom_base_enable_i & ~no_ext_mem_o
        & (mem_size_code_o > `SIZE_CODE_16BIT_MAX); // [R11]
      if (high_strobe_en_reg) begin
        gp_pin_or_addr_strobe_high_oe_n_o <= 1'b0;
        // One-cycle pulse, so the latch closes before the bus moves on
        gp_pin_or_addr_strobe_high_o <= ~((state_reg == ST_STRB)
          & (abyte_reg == 2'h2) & (cnt_reg == 4'h0)); // [R8]
      end else begin
        gp_pin_or_addr_strobe_high_oe_n_o <= gpio_oe_n_i;
        gp_pin_or_addr_strobe_high_o      <= gpio_out_i;
      end
    end
  end

  // Access sequencer
  always @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      state_reg <= ST_STRAP;
      abyte_reg <= 2'h0;
      beat_reg  <= 2'h0;
      cnt_reg   <= 4'h0;
      write_reg <= 1'b0;
      addr_reg  <= 20'h00000;
      rdata_reg <= 32'h00000000;
      mem_size_code_o <= `SIZE_CODE_NONE;
      slow_mem_o      <= 1'b0;
      no_ext_mem_o    <= 1'b1;
      req_ready_o     <= 1'b0;
      rsp_valid_o     <= 1'b0;
      rsp_rdata_o     <= 32'h00000000;
      local_addr_data_bus_o      <= 8'h00;
      local_addr_data_bus_oe_n_o <= 1'b1;
      addr_strobe_low_n_o    <= 1'b1;
      addr_strobe_mid_n_o    <= 1'b1;
      local_write_strobe_n_o <= 1'b1;
      local_read_enable_n_o  <= 1'b1;
      local_chip_select_n_o  <= 1'b1;
    end else begin
      rsp_valid_o <= 1'b0;
      case (state_reg)
        ST_STRAP: begin
          // Straps sampled once, after reset release, bus not driven
          mem_size_code_o <=
            local_addr_data_bus_i[`STRAP_SIZE_MSB:`STRAP_SIZE_LSB]; // [R17]
          no_ext_mem_o <= (local_addr_data_bus_i[`STRAP_SIZE_MSB:
            `STRAP_SIZE_LSB] == `SIZE_CODE_NONE); // [R17]
          slow_mem_o <= ~local_addr_data_bus_i[`STRAP_SLOW_BIT]; // [R16]
          req_ready_o <= 1'b1;
          state_reg <= ST_IDLE;
        end
        ST_IDLE: begin
          if (req_valid_i) begin
            req_ready_o <= 1'b0;
            write_reg <= req_write_i;
            addr_reg  <= {req_addr_i[19:2], 2'h0};
            rdata_reg <= req_wdata_i;
            abyte_reg <= first_abyte;
            beat_reg  <= 2'h0;
            state_reg <= ST_ADDR;
          end
        end
        ST_ADDR: begin
          // Address byte on the bus a cycle before its strobe
          local_addr_data_bus_oe_n_o <= 1'b0;
          local_addr_data_bus_o <= (abyte_reg == 2'h2)
            ? {4'h0, addr_reg[19:16]}
            : (abyte_reg == 2'h1) ? addr_reg[15:8] : addr_reg[7:0]; // [R8]
          state_reg <= ST_STRB;
        end
        ST_STRB: begin
          // Strobe low then back high, latch clocks on the rising edge
          if (cnt_reg == 4'h0) begin
            addr_strobe_mid_n_o <= ~(abyte_reg == 2'h1); // [R10]
            addr_strobe_low_n_o <= ~(abyte_reg == 2'h0); // [R9]
            cnt_reg <= `STROBE_CYCLES;
          end else begin
            addr_strobe_mid_n_o <= 1'b1;
            addr_strobe_low_n_o <= 1'b1;
            cnt_reg <= 4'h0;
            if (abyte_reg == 2'h0) begin
              state_reg <= ST_DATA; // [R18]
              cnt_reg <= data_cycles;
              local_chip_select_n_o <= 1'b0; // [R14]
              local_addr_data_bus_oe_n_o <= ~write_reg; // [R15]
              local_addr_data_bus_o <= lane_byte(rdata_reg, lane); // [R4]
              local_write_strobe_n_o <= ~write_reg; // [R12]
              local_read_enable_n_o  <= write_reg; // [R13]
            end else begin
              abyte_reg <= abyte_reg - 2'h1;
              state_reg <= ST_ADDR;
            end
          end
        end
        ST_DATA: begin
          // Data sampled and strobes released on the last cycle
          if (cnt_reg == 4'h1) begin
            local_write_strobe_n_o <= 1'b1;
            local_read_enable_n_o  <= 1'b1;
            state_reg <= write_reg ? ST_DONE : ST_NEXT;
          end
          cnt_reg <= cnt_reg - 4'h1;
        end
        ST_NEXT: begin
          // One read byte drained into its lane per visit
          if (fifo_out_valid) begin
            rdata_reg[lane*8 +: 8] <= fifo_out_data; // [R3] [R6] [R7]
          end
          state_reg <= ST_DONE;
        end
        ST_DONE: begin
          local_chip_select_n_o <= 1'b1;
          local_addr_data_bus_oe_n_o <= 1'b1;
          if (beat_reg == `LANE_LAST) begin
            rsp_valid_o <= 1'b1;
            rsp_rdata_o <= rdata_reg;
            req_ready_o <= 1'b1;
            state_reg <= ST_IDLE;
          end else begin
            // Next location: only the low byte is re-strobed
            beat_reg  <= beat_reg + 2'h1;
            addr_reg  <= addr_reg + 20'h00001;
            abyte_reg <= 2'h0;
            state_reg <= ST_ADDR;
          end
        end
        default: begin
          state_reg <= ST_IDLE;
        end
      endcase
    end
  end

endmodule

// *** test/local_mem_port_sva.sv ***
`timescale 1ns/100ps
module local_mem_port_sva (
  input wire       clk_i,
  input wire       nrst_i,
  input wire       rsp_valid_o,
  input wire       rom_base_enable_i,
  input wire       gpio_oe_n_i,
  input wire [7:0] dma_control_reg_i,
  input wire       irq_pending_i,
  input wire       irq_n_o,
  input wire       irq_oe_n_o,
  input wire       irq_pullup_o,
  input wire [2:0] mem_size_code_o,
  input wire       slow_mem_o,
  input wire       no_ext_mem_o,
  input wire       local_addr_data_bus_oe_n_o,
  input wire       addr_strobe_low_n_o,
  input wire       addr_strobe_mid_n_o,
  input wire       gp_pin_or_addr_strobe_high_o,
  input wire       gp_pin_or_addr_strobe_high_oe_n_o,
  input wire       local_write_strobe_n_o,
  input wire       local_read_enable_n_o,
  input wire       local_chip_select_n_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!nrst_i);
  // Data strobe low time in clocks; a counter keeps repetitions short
  reg  [3:0] dlen_reg;
  wire       dstb_n = local_read_enable_n_o & local_write_strobe_n_o;
  // Pin stays general purpose unless a wide ROM is enabled
  wire       gp_free = !rom_base_enable_i || mem_size_code_o <= 3'h2 ||
                       mem_size_code_o == 3'h7;
  always @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i)
      dlen_reg <= 4'h0;
    else
      dlen_reg <= dstb_n ? 4'h0 : dlen_reg + 4'h1;
  end
  // Bus ownership and strobe ordering
  chk_read_bus_free: assert property (
    !local_read_enable_n_o |-> !local_chip_select_n_o &&
    local_addr_data_bus_oe_n_o && local_write_strobe_n_o)
    else $error("read enable while bus driven or chip idle");
  chk_write_drives_bus: assert property (
    !local_write_strobe_n_o |-> !local_chip_select_n_o &&
    !local_addr_data_bus_oe_n_o && local_read_enable_n_o)
    else $error("write strobe without data on bus");
  chk_low_strobe_pulse: assert property (
    $fell(addr_strobe_low_n_o) |-> !local_addr_data_bus_oe_n_o &&
    local_chip_select_n_o ##1 addr_strobe_low_n_o)
    else $error("low address strobe malformed");
  chk_mid_strobe_pulse: assert property (
    $fell(addr_strobe_mid_n_o) |-> !local_addr_data_bus_oe_n_o &&
    local_chip_select_n_o ##1 addr_strobe_mid_n_o)
    else $error("mid address strobe malformed");
  chk_high_strobe_pulse: assert property (
    $fell(gp_pin_or_addr_strobe_high_o) && !gp_free |->
    !local_addr_data_bus_oe_n_o && local_chip_select_n_o
    ##1 gp_pin_or_addr_strobe_high_o)
    else $error("high address strobe malformed");
  chk_mid_before_low: assert property (
    $fell(addr_strobe_mid_n_o) |-> ##[1:8] $fell(addr_strobe_low_n_o))
    else $error("low byte did not follow mid byte");
  chk_high_strobe_gate: assert property (
    (gp_free && gpio_oe_n_i)[*3] |-> gp_pin_or_addr_strobe_high_oe_n_o)
    else $error("shared pin driven while general purpose");
  chk_irq_asserted: assert property (
    (irq_pending_i)[*2] |-> !irq_n_o && !irq_oe_n_o)
    else $error("pending interrupt not driven low");
  chk_irq_totem: assert property (
    (!irq_pending_i && dma_control_reg_i[3])[*2] |->
    irq_n_o && !irq_oe_n_o)
    else $error("totem pole interrupt not driven high");
  chk_irq_open_drain: assert property (
    (!irq_pending_i && !dma_control_reg_i[3])[*2] |->
    irq_oe_n_o && irq_pullup_o)
    else $error("open drain interrupt not released");
  chk_data_len: assert property (
    $rose(dstb_n) |-> dlen_reg == (slow_mem_o ? 4'h4 : 4'h2))
    else $error("data phase length wrong");
  chk_size_none: assert property (
    no_ext_mem_o == (mem_size_code_o == 3'h7))
    else $error("no memory flag disagrees with size code");
  chk_rsp_pulse: assert property (rsp_valid_o |=> !rsp_valid_o)
    else $error("response valid longer than one cycle");
  // Main scenarios reached
  cover property ($fell(local_read_enable_n_o));
  cover property ($fell(local_write_strobe_n_o));
  cover property ($fell(gp_pin_or_addr_strobe_high_oe_n_o) && gpio_oe_n_i);
endmodule

// *** test/latched_flash_model.sv ***
`timescale 1ns/100ps
module latched_flash_model (
  input  wire        clk_i,
  input  wire        nrst_i,
  input  wire [7:0]  idle_i,
  input  wire        slow_i,
  input  wire [7:0]  dev_data_i,
  input  wire        dev_oe_n_i,
  input  wire        stb_low_n_i,
  input  wire        stb_mid_n_i,
  input  wire        stb_high_n_i,
  input  wire        cs_n_i,
  input  wire        oe_n_i,
  input  wire        we_n_i,
  output wire [7:0]  bus_o,
  output reg  [31:0] wlog_o,
  output reg  [19:0] waddr_o
);
  reg  [7:0]  lo_reg, mid_reg, wbyte_reg;
  reg  [3:0]  hi_reg;
  reg  [1:0]  age_reg;
  reg         we_d_reg;
  wire [19:0] addr = {hi_reg, mid_reg, lo_reg};
  wire [7:0]  rd = addr[7:0] ^ addr[15:8] ^ {4'h0, addr[19:16]} ^ 8'hA5;
  wire        mem_on = !cs_n_i && !oe_n_i;
  // Slow parts show wrong data until their access time has passed
  wire        ready = age_reg >= (slow_i ? 2'h3 : 2'h1);
  // Undriven bus floats to pull-ups with strap pull-downs
  assign bus_o = !dev_oe_n_i ? dev_data_i : mem_on ? (ready ? rd : ~rd) :
                 idle_i;
  // Address latches, read access timer and write capture
  always @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      {lo_reg, mid_reg, hi_reg, age_reg, we_d_reg} <= 23'h1;
      {wbyte_reg, wlog_o, waddr_o} <= 60'h0;
    end else begin
      if (!stb_low_n_i) lo_reg <= bus_o;
      if (!stb_mid_n_i) mid_reg <= bus_o;
      if (!stb_high_n_i && !dev_oe_n_i) hi_reg <= bus_o[3:0];
      age_reg <= mem_on ? age_reg + {1'b0, age_reg != 2'h3} : 2'h0;
      we_d_reg <= we_n_i;
      if (!cs_n_i && !we_n_i) begin
        wbyte_reg <= bus_o;
        waddr_o   <= addr;
      end
      if (we_n_i && !we_d_reg) wlog_o <= {wbyte_reg, wlog_o[31:8]};
    end
  end
endmodule

// *** test/testbench.sv ***
`timescale 1ns/100ps
module testbench;
  logic        clk_i = 1'b0, nrst_i = 1'b0, req_valid_i = 1'b0;
  logic        req_write_i = 1'b0, byte_order_select_i = 1'b0;
  logic        rom_base_enable_i = 1'b1, irq_pending_i = 1'b0, slow = 1'b0;
  logic        gpio_out_i = 1'b1, gpio_oe_n_i = 1'b1;
  logic [19:0] req_addr_i = 20'h0;
  logic [31:0] req_wdata_i = 32'h0;
  logic [7:0]  dma_control_reg_i = 8'h0, idle = 8'hFF;
  wire         req_ready_o, rsp_valid_o, gpio_in_o, slow_mem_o, no_ext_mem_o;
  wire         irq_n_o, irq_oe_n_o, irq_pullup_o, local_addr_data_bus_oe_n_o;
  wire         addr_strobe_low_n_o, addr_strobe_mid_n_o;
  wire         local_write_strobe_n_o;
  wire         gp_pin_or_addr_strobe_high_o, gp_pin_or_addr_strobe_high_oe_n_o;
  wire         local_read_enable_n_o, local_chip_select_n_o;
  wire [2:0]   mem_size_code_o;
  wire [7:0]   local_addr_data_bus_o, bus;
  wire [31:0]  rsp_rdata_o, wlog_o;
  wire [19:0]  waddr_o;
  int          miscompares = 0, num_checks = 0, cycles = 0;
  // Shared pin has a pull-up when nobody drives it
  wire gp_lvl = gp_pin_or_addr_strobe_high_oe_n_o ? 1'b1 :
                gp_pin_or_addr_strobe_high_o;
  // Interrupt pin floats to its weak pull-up only when that is on
  wire irq_lvl = irq_oe_n_o ? irq_pullup_o : irq_n_o;
  local_mem_port dut (
    .clk_i, .nrst_i, .req_valid_i, .req_write_i, .req_addr_i, .req_wdata_i,
    .req_ready_o, .rsp_rdata_o, .rsp_valid_o, .byte_order_select_i,
    .rom_base_enable_i, .dma_control_reg_i, .irq_pending_i, .gpio_out_i,
    .gpio_oe_n_i, .gpio_in_o, .mem_size_code_o, .slow_mem_o, .no_ext_mem_o,
    .irq_n_o, .irq_oe_n_o, .irq_pullup_o, .local_addr_data_bus_i(bus),
    .local_addr_data_bus_o, .local_addr_data_bus_oe_n_o, .addr_strobe_low_n_o,
    .addr_strobe_mid_n_o, .gp_pin_or_addr_strobe_high_i(gp_lvl),
    .gp_pin_or_addr_strobe_high_o, .gp_pin_or_addr_strobe_high_oe_n_o,
    .local_write_strobe_n_o, .local_read_enable_n_o, .local_chip_select_n_o);
  latched_flash_model mem (
    .clk_i, .nrst_i, .idle_i(idle), .slow_i(slow),
    .dev_data_i(local_addr_data_bus_o),
    .dev_oe_n_i(local_addr_data_bus_oe_n_o),
    .stb_low_n_i(addr_strobe_low_n_o), .stb_mid_n_i(addr_strobe_mid_n_o),
    .stb_high_n_i(gp_lvl), .cs_n_i(local_chip_select_n_o),
    .oe_n_i(local_read_enable_n_o), .we_n_i(local_write_strobe_n_o),
    .bus_o(bus), .wlog_o, .waddr_o);
  // Clock and hang guard
  always #50 clk_i = ~clk_i;
  always @(posedge clk_i) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      miscompares = miscompares + 1;
      final_report;
    end
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks = num_checks + 1;
    if (got !== exp) begin
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
      miscompares = miscompares + 1;
    end
  endtask
  function automatic logic [31:0] exp_rd(input logic [19:0] a,
                                         input logic big);
    logic [19:0] b;
    for (int k = 0; k < 4; k++) begin
      b = a + 20'(k);
      exp_rd[8*(big ? 3-k : k) +: 8] = b[7:0] ^ b[15:8] ^ {4'h0, b[19:16]}
                                       ^ 8'hA5;
    end
  endfunction
  // Straps float on the bus while reset is released
  task automatic boot(input logic [7:0] strap, input logic sl);
    @(posedge clk_i);
    nrst_i <= 1'b0;
    idle   <= strap;
    slow   <= sl;
    repeat (2) @(posedge clk_i);
    nrst_i <= 1'b1;
    repeat (3) @(posedge clk_i);
  endtask
  task automatic access(input logic wr, input logic [19:0] a,
                        input logic [31:0] wd, output logic [31:0] rd);
    int n;
    n = 0;
    do begin @(posedge clk_i); n++; end
    while (req_ready_o !== 1'b1 && n < 300);
    req_valid_i <= 1'b1;
    req_write_i <= wr;
    req_addr_i  <= a;
    req_wdata_i <= wd;
    @(posedge clk_i);
    req_valid_i <= 1'b0;
    n = 0;
    do begin @(posedge clk_i); n++; end
    while (rsp_valid_o !== 1'b1 && n < 300);
    rd = rsp_rdata_o;
  endtask
  // One word written, then two back-to-back word reads
  task automatic wr_rd(input logic [19:0] a, input logic [31:0] wd,
                       input logic big);
    logic [31:0] rd, sw;
    // Location order of the word when lane three goes first
    sw = {wd[7:0], wd[15:8], wd[23:16], wd[31:24]};
    access(1'b1, a, wd, rd);
    repeat (2) @(posedge clk_i);
    chk(wlog_o, big ? sw : wd);
    chk(waddr_o, a + 20'h3);
    for (int k = 0; k < 2; k++) begin
      access(1'b0, a + 20'(4*k), 32'h0, rd);
      chk(rd, exp_rd(a + 20'(4*k), big));
    end
  endtask
  task final_report;
    $display("checks %0d mismatches %0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  initial begin
    boot(8'hFC, 1'b1);
    chk({mem_size_code_o, slow_mem_o, no_ext_mem_o}, 5'h1A);
    for (int b = 0; b < 2; b++) begin
      @(posedge clk_i);
      byte_order_select_i <= b[0];
      wr_rd(b ? 20'h5F3A8 : 20'hA5C34, 32'h11223344 + b, b[0]);
    end
    // Enable bit cleared: the shared pin falls back to general purpose
    rom_base_enable_i <= 1'b0;
    repeat (3) @(posedge clk_i);
    chk({gp_pin_or_addr_strobe_high_oe_n_o, gp_lvl}, 2'h3);
    rom_base_enable_i <= 1'b1;
    $display("test wide slow memory done");
    byte_order_select_i <= 1'b0;
    boot(8'hF5, 1'b0);
    chk({mem_size_code_o, slow_mem_o}, 4'h4);
    wr_rd(20'h0BE70, 32'hA1B2C3D4, 1'b0);
    gpio_oe_n_i <= 1'b0;
    gpio_out_i  <= 1'b0;
    repeat (3) @(posedge clk_i);
    chk({gp_pin_or_addr_strobe_high_oe_n_o, gp_lvl, gpio_in_o}, 3'h0);
    gpio_oe_n_i <= 1'b1;
    gpio_out_i  <= 1'b1;
    $display("test narrow fast memory done");
    boot(8'hFF, 1'b0);
    chk({mem_size_code_o, no_ext_mem_o}, 4'hF);
    $display("test no memory done");
    for (int m = 0; m < 4; m++) begin
      dma_control_reg_i <= {4'h0, m[1], 3'h0};
      irq_pending_i     <= m[0];
      repeat (3) @(posedge clk_i);
      chk({irq_lvl, irq_oe_n_o}, {~m[0], ~m[1] & ~m[0]});
    end
    $display("test interrupt drive done");
    final_report;
  end
endmodule
bind local_mem_port local_mem_port_sva u_sva (
  .clk_i, .nrst_i, .rsp_valid_o, .rom_base_enable_i, .gpio_oe_n_i,
  .dma_control_reg_i, .irq_pending_i, .irq_n_o, .irq_oe_n_o, .irq_pullup_o,
  .mem_size_code_o, .slow_mem_o, .no_ext_mem_o, .local_addr_data_bus_oe_n_o,
  .addr_strobe_low_n_o, .addr_strobe_mid_n_o,
  .gp_pin_or_addr_strobe_high_o, .gp_pin_or_addr_strobe_high_oe_n_o,
  .local_write_strobe_n_o,
  .local_read_enable_n_o, .local_chip_select_n_o);
